// File: common/sscd_pkg.sv
// Package for the swap, supervisor-call and coprocessor decode block
`default_nettype none
package sscd_pkg;
	// ============================================================
	// Instruction field positions
	localparam int COND_HI = 31;
	localparam int COND_LO = 28;
	localparam int CLASS_HI = 27;
	localparam int CLASS_LO = 24;
	localparam int CPNUM_HI = 11;
	localparam int CPNUM_LO = 8;
	localparam int BYTE_BIT = 22;
	localparam int XFER_BIT = 4;
	localparam int BASE_HI = 19;
	localparam int BASE_LO = 16;
	localparam int DEST_HI = 15;
	localparam int DEST_LO = 12;
	localparam int SRC_HI = 3;
	localparam int SRC_LO = 0;
	localparam int LOAD_BIT = 20;
	// ============================================================
	// Class codes in bits 27..24
	localparam logic [3:0] CLS_SVC = 4'hf;
	localparam logic [3:0] CLS_CPOP = 4'he;
	localparam logic [2:0] CLS_CPLS = 3'h6;
	// Swap pattern: bits 27..23, 21..20 and 11..4
	localparam logic [4:0] SWAP_HI_PAT = 5'h02;
	localparam logic [7:0] SWAP_LO_PAT = 8'h09;
	// Internal coprocessor number
	localparam logic [3:0] INT_CP_NUM = 4'hf;
	// ============================================================
	// Vectors, modes, and timing counts
	localparam logic [31:0] SVC_VECTOR = 32'h0000_0008;
	localparam logic [31:0] UNDEF_VECTOR = 32'h0000_0004;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_UND = 5'h1b;
	localparam logic [31:0] WORD_STEP = 32'h0000_0004;
	localparam logic [1:0] SVC_FETCHES = 2'h3;
	localparam logic [1:0] CPREG_INTERNALS = 2'h3;
	localparam logic [31:0] CPREG_RESET = 32'h0000_0000;
	// Status word flag positions
	localparam int FLAG_N = 31;
	localparam int FLAG_Z = 30;
	localparam int FLAG_C = 29;
	localparam int FLAG_V = 28;
	// ============================================================
	// Sequencer states, Gray coded along the swap path
	typedef enum logic [2:0] {
		SSCD_IDLE = 3'h0,
		SSCD_READ = 3'h1,
		SSCD_WRITE = 3'h3,
		SSCD_INTERNAL = 3'h2,
		SSCD_FETCH = 3'h6,
		SSCD_CPREG = 3'h7
	} sscd_state_e;
	// Memory request bundle toward the memory system
	typedef struct packed {
		logic valid;
		logic write;
		logic byte_sel;
		logic locked;
		logic [31:0] addr;
		logic [31:0] wdata;
	} sscd_mem_req_s;
	// Trap bundle toward the core
	typedef struct packed {
		logic take;
		logic [4:0] mode;
		logic [31:0] vector;
		logic [31:0] link;
		logic [31:0] saved_status;
	} sscd_trap_s;
endpackage
`default_nettype wire

// File: dv/sscd_checker.sv
// Port-level assertions for the swap, call and coprocessor decode block
`default_nettype none
module sscd_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic instr_valid,
	input wire logic [31:0] instr,
	input wire logic [31:0] instr_addr,
	input wire logic [31:0] status_word,
	input wire logic mem_ready,
	input wire logic busy,
	input wire logic fetch_cycle,
	input wire logic internal_cycle,
	input wire sscd_pkg::sscd_mem_req_s mem_req,
	input wire sscd_pkg::sscd_trap_s trap,
	input wire logic dest_we
);
	// ============================================================
	// Clocking and reset shared by every property
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// ============================================================
	// Assertions
	chk_lock_held: assert property (mem_req.valid |-> mem_req.locked)
		else $error("lock low during swap access");
	chk_read_first: assert property (clk_en && mem_req.valid
		&& !mem_req.write && mem_ready |=> mem_req.valid && mem_req.write)
		else $error("swap read not followed by write");
	chk_write_last: assert property (clk_en && mem_req.valid
		&& mem_req.write && mem_ready |=> internal_cycle && !mem_req.valid)
		else $error("swap write not followed by internal cycle");
	chk_byte_lane: assert property (mem_req.valid && mem_req.write
		&& mem_req.byte_sel |-> mem_req.wdata[31:8] == 24'h0)
		else $error("byte swap drives upper bits");
	chk_svc_entry: assert property (trap.take
		&& trap.mode == sscd_pkg::MODE_SVC
		|-> trap.vector == sscd_pkg::SVC_VECTOR
		&& trap.saved_status == $past(status_word))
		else $error("call entry vector or saved status wrong");
	chk_svc_link: assert property (trap.take
		&& trap.mode == sscd_pkg::MODE_SVC
		|-> trap.link == $past(instr_addr) + sscd_pkg::WORD_STEP)
		else $error("call link address wrong");
	chk_three_fetch: assert property (trap.take
		|-> fetch_cycle[*3] ##1 !fetch_cycle)
		else $error("trap refill not three fetches");
	chk_undef_trap: assert property (trap.take
		&& trap.mode != sscd_pkg::MODE_SVC
		|-> trap.mode == sscd_pkg::MODE_UND
		&& trap.vector == sscd_pkg::UNDEF_VECTOR)
		else $error("undefined trap mode or vector wrong");
	chk_never_cond: assert property (clk_en && instr_valid
		&& !busy && instr[31:28] == 4'hf |=> !busy && !trap.take)
		else $error("never condition executed");
	// ============================================================
	// Main scenario coverage
	cov_swap_write: cover property (mem_req.valid && mem_req.write);
	cov_svc_take: cover property (trap.take
		&& trap.mode == sscd_pkg::MODE_SVC);
	cov_und_take: cover property (trap.take
		&& trap.mode == sscd_pkg::MODE_UND);
	cov_dest: cover property (dest_we);
endmodule
bind sscd_decode sscd_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.clk_en(clk_en), .instr_valid(instr_valid), .instr(instr),
	.instr_addr(instr_addr), .status_word(status_word),
	.mem_ready(mem_ready), .busy(busy), .fetch_cycle(fetch_cycle),
	.internal_cycle(internal_cycle), .mem_req(mem_req), .trap(trap),
	.dest_we(dest_we));
`default_nettype wire

// File: dv/sscd_decode_tb.sv
// Self-checking bench for the decode block
`default_nettype none
module sscd_decode_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {
		logic [31:0] ins, st;
		logic [31:0] take;
		logic [4:0] mode;
		logic [31:0] nint, dwe, data;
	} sscd_row_s;
	localparam logic [4:0] SVM = sscd_pkg::MODE_SVC;
	localparam logic [4:0] UNM = sscd_pkg::MODE_UND;
	// Stimulus and observation
	logic ref_clk = 0, rst_n = 0, clk_en = 1, instr_valid = 0;
	logic [31:0] instr = 0, instr_addr = 0, status_word = 0;
	logic [31:0] base_value = 0, source_value = 0;
	logic [31:0] core_reg_value = 32'h5a5a_00c3;
	logic [1:0] wait_cycles = 0;
	logic busy, fetch_cycle, internal_cycle, mem_ready, dest_we, flags_we;
	logic [3:0] dest_idx, flags_data;
	logic [31:0] dest_data, mem_rdata;
	sscd_pkg::sscd_mem_req_s mem_req;
	sscd_pkg::sscd_trap_s trap;
	int n_fail = 0, check_count = 0, cyc = 0;
	logic [31:0] ntake, nrd, nwr, nint, nf, ndwe, tvec, tlink, tsav, ddata;
	logic [31:0] nfw, fdata, didx;
	logic [4:0] tmode;
	sscd_row_s rows [12] = '{
		'{32'hef12_3456, 0, 1, SVM, 0, 0, 0},
		'{32'h0f00_00ff, 0, 0, 0, 0, 0, 0},
		'{32'h0fab_cdef, 32'h4000_0000, 1, SVM, 0, 0, 0},
		'{32'hff00_0000, 0, 0, 0, 0, 0, 0},
		'{32'hee12_3103, 0, 1, UNM, 0, 0, 0},
		'{32'hee12_3f03, 0, 1, UNM, 0, 0, 0},
		'{32'hed90_1f00, 0, 1, UNM, 0, 0, 0},
		'{32'hec80_1200, 0, 1, UNM, 0, 0, 0},
		'{32'hee01_0110, 0, 1, UNM, 0, 0, 0},
		'{32'hee11_2f10, 0, 0, 0, 3, 1, 0},
		'{32'hee01_2f10, 0, 0, 0, 3, 0, 0},
		'{32'hee11_2f10, 0, 0, 0, 3, 1, 32'h5a5a_00c3}};
	// ============================================================
	// Clock, design and memory
	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	sscd_decode uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.instr_valid(instr_valid), .instr(instr), .instr_addr(instr_addr),
		.status_word(status_word), .base_value(base_value),
		.source_value(source_value), .core_reg_value(core_reg_value),
		.mem_ready(mem_ready), .mem_rdata(mem_rdata), .busy(busy),
		.fetch_cycle(fetch_cycle), .internal_cycle(internal_cycle),
		.mem_req(mem_req), .dest_we(dest_we), .dest_idx(dest_idx),
		.dest_data(dest_data), .flags_we(flags_we),
		.flags_data(flags_data), .trap(trap));
	sscd_mem_model mdl (.ref_clk(ref_clk), .rst_n(rst_n), .mem_req(mem_req),
		.wait_cycles(wait_cycles), .mem_ready(mem_ready),
		.mem_rdata(mem_rdata));
	// ============================================================
	// Tasks
	task chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	// Issue one instruction and tally the cycles that follow
	task automatic run(input logic [31:0] ins, st, a);
		@(posedge ref_clk);
		instr <= ins;
		status_word <= st;
		instr_addr <= a;
		instr_valid <= 1'b1;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		{ntake, nrd, nwr, nint, nf, ndwe, nfw} = '0;
		repeat (14) begin
			@(negedge ref_clk);
			// Frozen cycles are not processor cycles
			if (!clk_en) continue;
			if (trap.take) begin
				ntake++;
				{tmode, tvec, tlink, tsav} = {trap.mode, trap.vector,
					trap.link, trap.saved_status};
			end
			if (mem_req.valid && mem_ready && mem_req.write) nwr++;
			if (mem_req.valid && mem_ready && !mem_req.write) nrd++;
			nint += 32'(internal_cycle);
			nf += 32'(fetch_cycle);
			if (dest_we) begin
				ndwe++;
				ddata = dest_data;
				didx = 32'(dest_idx);
			end
			if (flags_we) begin
				nfw++;
				fdata = 32'(flags_data);
			end
		end
		chk(32'(busy), 0);
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			end_of_test;
		end
	end
	// ============================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		chk(32'({busy, mem_req.valid, trap.take}), 0);
		foreach (rows[i]) begin
			run(rows[i].ins, rows[i].st, 32'h100 + 32'(i * 4));
			chk(ntake, rows[i].take);
			chk(nint, rows[i].nint);
			chk(ndwe, rows[i].dwe);
			if (rows[i].dwe == 1) chk(ddata, rows[i].data);
			if (rows[i].take == 1) begin
				chk(32'(tmode), 32'(rows[i].mode));
				chk(nf, 3);
				chk(nint, 0);
			end
			if (rows[i].take == 1 && rows[i].mode == SVM) begin
				chk(tvec, 32'h8);
				chk(tsav, rows[i].st);
				chk(tlink, 32'h104 + 32'(i * 4));
			end
		end
		$display("table rows done");
		// Word swap against a slow memory
		mdl.mem[1] = 32'h1234_5678;
		wait_cycles <= 2'h2;
		base_value <= 32'h4;
		source_value <= 32'hcafe_f00d;
		run(32'he102_1093, 0, 32'h200);
		chk(nrd + nwr + nint, 3);
		chk(ddata, 32'h1234_5678);
		chk(didx, 32'h1);
		chk(mdl.mem[1], 32'hcafe_f00d);
		// Byte swap against a prompt memory
		wait_cycles <= 2'h0;
		source_value <= 32'h1111_11a5;
		run(32'he142_1093, 0, 32'h204);
		chk(ddata, 32'h0000_000d);
		chk(mdl.mem[1], 32'hcafe_f0a5);
		$display("swap tests done");
		// Move to the flags only, then a move frozen by the clock enable
		run(32'hee11_ff10, 0, 32'h208);
		chk(ndwe, 0);
		chk(nfw, 1);
		chk(fdata, 32'h5);
		fork
			run(32'hee11_2f10, 0, 32'h20c);
			begin
				repeat (2) @(posedge ref_clk);
				clk_en <= 1'b0;
				repeat (3) @(posedge ref_clk);
				clk_en <= 1'b1;
			end
		join
		chk(nint, 3);
		chk(ndwe, 1);
		chk(nfw, 0);
		chk(ddata, 32'h5a5a_00c3);
		chk(didx, 32'h2);
		$display("move tests done");
		// Second reset lands in the middle of a call refill
		@(posedge ref_clk);
		instr <= 32'hef00_0000;
		instr_valid <= 1'b1;
		@(posedge ref_clk);
		instr_valid <= 1'b0;
		@(negedge ref_clk);
		chk(32'(fetch_cycle), 1);
		rst_n <= 1'b0;
		@(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		chk(32'({busy, fetch_cycle, mem_req.valid, trap.take}), 0);
		run(32'hef00_0000, 0, 32'h210);
		chk(ntake, 1);
		chk(nf, 3);
		$display("reset test done");
		end_of_test;
	end
endmodule
`default_nettype wire

// File: dv/sscd_mem_model.sv
// Behavioural memory system answering swap read and write cycles
`default_nettype none
module sscd_mem_model (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire sscd_pkg::sscd_mem_req_s mem_req,
	input wire logic [1:0] wait_cycles,
	output logic mem_ready,
	output logic [31:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem [16]; // Sixteen words of storage
	logic [1:0] cnt; // Wait states spent on this cycle
	wire logic [3:0] idx = mem_req.addr[5:2]; // Word select
	// ============================================================
	// Ready after the chosen wait; released data reads inverted
	// Memory returns data
	assign mem_ready = mem_req.valid && (cnt == wait_cycles);
	assign mem_rdata = mem_ready ? mem[idx] : ~mem[idx];
	// Wait counter and storage update
	// Pair never split
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 2'h0;
		end else if (mem_req.valid && !mem_ready) begin
			cnt <= cnt + 2'h1;
		end else begin
			cnt <= 2'h0;
		end
		// Byte writes touch lane zero only
		if (rst_n && mem_ready && mem_req.write) begin
			if (mem_req.byte_sel) mem[idx][7:0] <= mem_req.wdata[7:0];
			else mem[idx] <= mem_req.wdata;
		end
	end
endmodule
`default_nettype wire

// File: rtl/sscd_cpreg_file.sv
// Internal coprocessor control register file with registered read data
`default_nettype none
module sscd_cpreg_file (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [3:0] wr_idx,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] rd_idx,
	output logic [31:0] rd_data
);
	// ============================================================
	// Storage, one word per register index
	logic [31:0] mem_reg [16];

	// One generate loop writes each entry
	for (genvar i = 0; i < 16; i++) begin : g_ent
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				mem_reg[i] <= sscd_pkg::CPREG_RESET;
			end else if (clk_en && wr_en && wr_idx == 4'(i)) begin
				mem_reg[i] <= wr_data;
			end
		end
	end

	// Registered read port
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= sscd_pkg::CPREG_RESET;
		end else if (clk_en) begin
			rd_data <= mem_reg[rd_idx];
		end
	end
endmodule
`default_nettype wire

// File: rtl/sscd_decode.sv
// Swap, supervisor-call and coprocessor instruction decode and sequencer
// Behaviour
// - Swap: fetch, read, write, internal cycle
// - Byte bit selects byte or word
// - Byte swap writes only source bits 7:0
// - Execute only when condition passes
// - Supervisor call: svc mode, save status, vector
// - Link gets address of following word
// - Low 24 bits of call ignored
// - Supervisor call costs three fetches
// - Only coprocessor 15 register transfers execute
// - Other coprocessor instructions take undefined trap
// - Data op decode uses bits 4, 31:24
// - Data op: no wait, no result
// - Coproc transfer: core addresses, coproc data
// - Swap reads base, writes source, returns old
// - Lock held across swap read and write
`default_nettype none
module sscd_decode (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic instr_valid,
	input wire logic [31:0] instr,
	input wire logic [31:0] instr_addr,
	input wire logic [31:0] status_word,
	input wire logic [31:0] base_value,
	input wire logic [31:0] source_value,
	input wire logic [31:0] core_reg_value,
	input wire logic mem_ready,
	input wire logic [31:0] mem_rdata,
	output logic busy,
	output logic fetch_cycle,
	output logic internal_cycle,
	output sscd_pkg::sscd_mem_req_s mem_req,
	output logic dest_we,
	output logic [3:0] dest_idx,
	output logic [31:0] dest_data,
	output logic flags_we,
	output logic [3:0] flags_data,
	output sscd_pkg::sscd_trap_s trap
);
	// ============================================================
	// Field extraction
	wire logic [3:0] cond_f = instr[sscd_pkg::COND_HI:sscd_pkg::COND_LO];
	wire logic [3:0] class_f = instr[sscd_pkg::CLASS_HI:sscd_pkg::CLASS_LO];
	wire logic [3:0] coproc_number_field =
		instr[sscd_pkg::CPNUM_HI:sscd_pkg::CPNUM_LO];
	wire logic nf = status_word[sscd_pkg::FLAG_N];
	wire logic zf = status_word[sscd_pkg::FLAG_Z];
	wire logic cf = status_word[sscd_pkg::FLAG_C];
	wire logic vf = status_word[sscd_pkg::FLAG_V];

	// ============================================================
	// Condition evaluation
	logic cond_base;
	always_comb begin
		case (cond_f[3:1])
			3'h0: cond_base = zf;
			3'h1: cond_base = cf;
			3'h2: cond_base = nf;
			3'h3: cond_base = vf;
			3'h4: cond_base = cf & ~zf;
			3'h5: cond_base = (nf == vf);
			3'h6: cond_base = ~zf & (nf == vf);
			default: cond_base = 1'b1;
		endcase
	end
	wire logic cond_pass = (cond_f == 4'hf) ? 1'b0 :
		(cond_base ^ (cond_f[0] & (cond_f[3:1] != 3'h7)));

	// ============================================================
	// Class decode
	// Call decode ignores low bits
	wire logic is_svc = (class_f == sscd_pkg::CLS_SVC);
	// Data op looks at 31:24 and bit 4 only
	wire logic is_cpop = (class_f == sscd_pkg::CLS_CPOP) &&
		!instr[sscd_pkg::XFER_BIT];
	wire logic is_cpreg = (class_f == sscd_pkg::CLS_CPOP) &&
		instr[sscd_pkg::XFER_BIT];
	// Coproc loads and stores trap for emulation
	wire logic is_cpls = (class_f[3:1] == sscd_pkg::CLS_CPLS);
	wire logic is_swap = (instr[27:23] == sscd_pkg::SWAP_HI_PAT) &&
		(instr[21:20] == 2'h0) && (instr[11:4] == sscd_pkg::SWAP_LO_PAT);
	// Only the internal coprocessor's transfers run
	wire logic cpreg_ok = is_cpreg &&
		(coproc_number_field == sscd_pkg::INT_CP_NUM);
	// Data ops trap at once, no result awaited
	wire logic cp_undef = is_cpop || is_cpls || (is_cpreg && !cpreg_ok);
	wire logic go = instr_valid && cond_pass && !busy;

	// ============================================================
	// State and captured operands
	sscd_pkg::sscd_state_e state_reg, state_next;
	logic [31:0] addr_reg;
	logic [31:0] src_reg;
	logic byte_reg;
	logic [3:0] dst_reg;
	logic [31:0] old_reg;
	logic [1:0] cnt_reg;
	logic load_reg;
	logic [3:0] cpidx_reg;
	logic [31:0] cp_rd;

	// Next-state selection
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sscd_pkg::SSCD_IDLE: begin
				if (go && is_swap) begin
					state_next = sscd_pkg::SSCD_READ;
				end else if (go && (is_svc || cp_undef)) begin
					state_next = sscd_pkg::SSCD_FETCH;
				end else if (go && cpreg_ok) begin
					state_next = sscd_pkg::SSCD_CPREG;
				end
			end
			sscd_pkg::SSCD_READ: begin
				if (mem_ready) begin
					state_next = sscd_pkg::SSCD_WRITE;
				end
			end
			sscd_pkg::SSCD_WRITE: begin
				if (mem_ready) begin
					state_next = sscd_pkg::SSCD_INTERNAL;
				end
			end
			sscd_pkg::SSCD_INTERNAL: state_next = sscd_pkg::SSCD_IDLE;
			// Three fetch cycles for the trap refill
			sscd_pkg::SSCD_FETCH: begin
				// Counter runs 2, 1, 0: leave on zero
				if (cnt_reg == 2'h0) begin
					state_next = sscd_pkg::SSCD_IDLE;
				end
			end
			sscd_pkg::SSCD_CPREG: begin
				// Three internal cycles, leave on zero
				if (cnt_reg == 2'h0) begin
					state_next = sscd_pkg::SSCD_IDLE;
				end
			end
			default: state_next = sscd_pkg::SSCD_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= sscd_pkg::SSCD_IDLE;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// Cycle counter for fetch and internal sequences
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 2'h0;
		end else if (clk_en && go) begin
			cnt_reg <= is_svc || cp_undef ? sscd_pkg::SVC_FETCHES - 2'h1 :
				sscd_pkg::CPREG_INTERNALS - 2'h1;
		end else if (clk_en && cnt_reg != 2'h0) begin
			cnt_reg <= cnt_reg - 2'h1;
		end
	end

	// Operand capture at instruction accept
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_reg <= 32'h0;
			src_reg <= 32'h0;
			byte_reg <= 1'b0;
			dst_reg <= 4'h0;
			load_reg <= 1'b0;
			cpidx_reg <= 4'h0;
		end else if (clk_en && go) begin
			addr_reg <= base_value;
			src_reg <= source_value;
			byte_reg <= instr[sscd_pkg::BYTE_BIT];
			dst_reg <= instr[sscd_pkg::DEST_HI:sscd_pkg::DEST_LO];
			load_reg <= instr[sscd_pkg::LOAD_BIT];
			cpidx_reg <= instr[sscd_pkg::BASE_HI:sscd_pkg::BASE_LO];
		end
	end

	// Old memory value captured on read completion
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			old_reg <= 32'h0;
		end else if (clk_en && state_reg == sscd_pkg::SSCD_READ && mem_ready) begin
			// Byte read zero-extends bits 7:0 of the read data, whatever the low address bits
			old_reg <= byte_reg ? {24'h0, mem_rdata[7:0]} : mem_rdata;
		end
	end

	// ============================================================
	// Internal coprocessor register file
	wire logic cp_wr = clk_en && go && cpreg_ok &&
		!instr[sscd_pkg::LOAD_BIT];
	sscd_cpreg_file u_cpreg (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.wr_en(cp_wr),
		.wr_idx(instr[sscd_pkg::BASE_HI:sscd_pkg::BASE_LO]),
		.wr_data(core_reg_value),
		.rd_idx(cpidx_reg),
		.rd_data(cp_rd)
	);

	// ============================================================
	// Memory request, handshake outputs
	wire logic in_rd = (state_reg == sscd_pkg::SSCD_READ);
	wire logic in_wr = (state_reg == sscd_pkg::SSCD_WRITE);
	always_comb begin
		mem_req.valid = in_rd | in_wr;
		mem_req.write = in_wr;
		mem_req.byte_sel = byte_reg;
		mem_req.locked = in_rd | in_wr;
		mem_req.addr = addr_reg;
		// Only low byte of source on byte swap
		mem_req.wdata = byte_reg ? {24'h0, src_reg[7:0]} : src_reg;
	end
	assign busy = (state_reg != sscd_pkg::SSCD_IDLE);
	assign fetch_cycle = (state_reg == sscd_pkg::SSCD_FETCH);
	assign internal_cycle = (state_reg == sscd_pkg::SSCD_INTERNAL) ||
		(state_reg == sscd_pkg::SSCD_CPREG);

	// ============================================================
	// Register writeback and trap outputs, registered
	wire logic swap_done = (state_reg == sscd_pkg::SSCD_INTERNAL);
	wire logic cp_done = (state_reg == sscd_pkg::SSCD_CPREG) &&
		(cnt_reg == 2'h0) && load_reg;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dest_we <= 1'b0;
			dest_idx <= 4'h0;
			dest_data <= 32'h0;
			flags_we <= 1'b0;
			flags_data <= 4'h0;
		end else if (clk_en) begin
			dest_we <= swap_done || (cp_done && dst_reg != 4'hf);
			dest_idx <= dst_reg;
			dest_data <= swap_done ? old_reg : cp_rd;
			flags_we <= cp_done && dst_reg == 4'hf;
			flags_data <= cp_rd[31:28];
		end
	end

	// Trap entry on call or undefined coprocessor op
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			trap <= '0;
		end else if (clk_en) begin
			trap.take <= go && (is_svc || cp_undef);
			trap.mode <= is_svc ? sscd_pkg::MODE_SVC : sscd_pkg::MODE_UND;
			trap.vector <= is_svc ? sscd_pkg::SVC_VECTOR :
				sscd_pkg::UNDEF_VECTOR;
			trap.link <= instr_addr + sscd_pkg::WORD_STEP;
			trap.saved_status <= status_word;
		end
	end
endmodule
`default_nettype wire
